// file: core/bpr_pkg.sv
// shared types, register map and timing constants of the parity report block
`default_nettype none
package bpr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // transaction descriptors handed over by the bridge core
   typedef enum logic [1:0] {
      XACT_READ    = 2'b00,
      XACT_POSTED  = 2'b01,
      XACT_DELAYED = 2'b11
   } bpr_xact_e;

   typedef enum logic {
      DIR_DOWN = 1'b0,
      DIR_UP   = 1'b1
   } bpr_dir_e;

   // one finished data phase on a bus, with the parity check result
   typedef struct packed {
      logic      done;
      logic      bad_par;
      bpr_xact_e kind;
      bpr_dir_e  dir;
   } bpr_phase_s;

   // bridge masters a write on a bus; fwd marks data carrying forwarded bad parity
   typedef struct packed {
      logic active;
      logic fwd;
   } bpr_master_s;

   // posted write data handed to the opposite bus
   typedef struct packed {
      logic valid;
      logic bad_par;
   } bpr_fwd_s;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets (byte addresses)
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_STAT = 4'h4;
   localparam logic [3:0] ADR_MASK = 4'h8;

   // control fields
   localparam int CTRL_W          = 4;
   localparam int CTRL_PRI_PER    = 0;
   localparam int CTRL_SEC_PER    = 1;
   localparam int CTRL_SERR_EN    = 2;
   localparam int CTRL_PW_EVT_DIS = 3;

   // status and mask fields
   localparam int STAT_W        = 5;
   localparam int STAT_PRI_DPE  = 0;
   localparam int STAT_SEC_DPE  = 1;
   localparam int STAT_PRI_MDPD = 2;
   localparam int STAT_SEC_MDPD = 3;
   localparam int STAT_SIG_SERR = 4;

   // reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
   localparam logic [STAT_W-1:0] STAT_RST = 5'h00;
   localparam logic [STAT_W-1:0] MASK_RST = 5'h00;

   // parity error pin is driven this many cycles after the data phase
   localparam int PERR_DLY = 2;

endpackage : bpr_pkg
`default_nettype wire

// file: core/bpr_sync3.sv
// three-stage pin synchroniser with agreement filter
`default_nettype none
module bpr_sync3 #(
   parameter logic RST_VAL = 1'b1
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // raw pin and filtered level
   input  wire logic pin_i,
   output logic      lvl_o
);

   logic [2:0] sh_q;
   logic [2:0] sh_d;
   logic       lvl_q;
   logic       lvl_d;

   // the first stage feeds only the second; the level moves when stages two and three agree
   always_comb begin
      sh_d  = {sh_q[1:0], pin_i};
      lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sh_q  <= {3{RST_VAL}};
         lvl_q <= RST_VAL;
      end else begin
         sh_q  <= sh_d;
         lvl_q <= lvl_d;
      end
   end

   assign lvl_o = lvl_q;

endmodule : bpr_sync3
`default_nettype wire

// file: core/bpr_parity_report.sv
// posted write parity detection, forwarding and error reporting with wishbone registers
`default_nettype none

// What this block does
// RQ1: a downstream posted write with bad primary parity drives the upstream parity pin two cycles later when primary response is on.
// RQ2: that same event always sets the primary detected-parity status bit.
// RQ3: downstream posted write data goes on to the secondary bus with its bad parity and completes normally.
// RQ4: an upstream posted write with bad secondary parity sets the secondary detected bit and, with secondary response on, drives the downstream parity pin two cycles later.
// RQ5: upstream posted write data goes on to the primary bus with its bad parity and completes normally.
// RQ6: a target parity report on the secondary pin during a downstream write sets the secondary master parity bit when secondary response is on.
// RQ7: that downstream report raises the system error pin and flag only with error enable, event disable clear, both responses on and no forwarded parity.
// RQ8: a target parity report on the primary pin during an upstream write sets the primary master parity bit when primary response is on.
// RQ9: that upstream report raises the system error pin and flag only with error enable, both responses on and no forwarded parity.
// RQ10: a target report about parity that was forwarded from the initiating bus never raises the system error pin.
// RQ11: the primary detected bit is set only by primary errors on upstream reads and downstream posted or delayed writes, whatever the responses.
// RQ12: the secondary detected bit is set only by secondary errors on downstream reads and upstream posted or delayed writes, whatever the responses.
module bpr_parity_report
   import bpr_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // data phases and master writes reported by the bridge core
   input  wire bpr_phase_s  pri_phase_i,
   input  wire bpr_phase_s  sec_phase_i,
   input  wire bpr_master_s pri_master_i,
   input  wire bpr_master_s sec_master_i,
   // posted write forwarding and normal completion to the core
   output bpr_fwd_s         sec_fwd_o,
   output bpr_fwd_s         pri_fwd_o,
   output logic             pri_cmpl_o,
   output logic             sec_cmpl_o,
   // parity and system error pins
   input  wire logic        upstream_side_parity_err_n_i,
   output logic             upstream_side_parity_err_n_o,
   output logic             upstream_side_parity_err_n_oe_o,
   input  wire logic        downstream_side_parity_err_n_i,
   output logic             downstream_side_parity_err_n_o,
   output logic             downstream_side_parity_err_n_oe_o,
   output logic             upstream_side_system_err_n_o,
   output logic             upstream_side_system_err_n_oe_o,
   // interrupt
   output logic             irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   // parity error seen on the bus where the bridge receives data
   function automatic logic recv_err(input bpr_phase_s ph, input bpr_dir_e rd_dir);
      logic wr_dir;
      wr_dir = (ph.dir != rd_dir);
      return ph.done && ph.bad_par &&
             ((ph.kind == XACT_READ) ? (ph.dir == rd_dir) : wr_dir);
   endfunction : recv_err

   // posted write finished as target on this bus
   function automatic logic posted_in(input bpr_phase_s ph, input bpr_dir_e dir);
      return ph.done && (ph.kind == XACT_POSTED) && (ph.dir == dir);
   endfunction : posted_in

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers for target parity reports

   logic pri_perr_lvl;
   logic sec_perr_lvl;

   bpr_sync3 #(.RST_VAL(1'b1)) u_pri_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pin_i (upstream_side_parity_err_n_i),
      .lvl_o (pri_perr_lvl)
   );

   bpr_sync3 #(.RST_VAL(1'b1)) u_sec_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pin_i (downstream_side_parity_err_n_i),
      .lvl_o (sec_perr_lvl)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register state

   logic [CTRL_W-1:0] ctrl_q;
   logic [CTRL_W-1:0] ctrl_d;
   logic [STAT_W-1:0] stat_q;
   logic [STAT_W-1:0] stat_d;
   logic [STAT_W-1:0] mask_q;
   logic [STAT_W-1:0] mask_d;
   logic              ack_q;
   logic              ack_d;
   logic [31:0]       rdat_q;
   logic [31:0]       rdat_d;

   logic pri_per;
   logic sec_per;
   logic serr_en;
   logic pw_dis;

   assign pri_per = ctrl_q[CTRL_PRI_PER];
   assign sec_per = ctrl_q[CTRL_SEC_PER];
   assign serr_en = ctrl_q[CTRL_SERR_EN];
   assign pw_dis  = ctrl_q[CTRL_PW_EVT_DIS];

   ////////////////////////////////////////////////////////////////////////////
   // event decode

   logic pri_det;
   logic sec_det;
   logic pri_pw_err;
   logic sec_pw_err;
   logic pri_perr_old_q;
   logic sec_perr_old_q;
   logic pri_tgt_rep;
   logic sec_tgt_rep;
   logic serr_down;
   logic serr_up;

   // detected bits ignore the response controls
   assign pri_det = recv_err(pri_phase_i, DIR_UP);   // RQ11
   assign sec_det = recv_err(sec_phase_i, DIR_DOWN); // RQ12

   // bad parity on a posted write taken as target
   assign pri_pw_err = posted_in(pri_phase_i, DIR_DOWN) && pri_phase_i.bad_par;
   assign sec_pw_err = posted_in(sec_phase_i, DIR_UP) && sec_phase_i.bad_par;

   // falling edge of the filtered pin while the bridge masters a write there
   assign pri_tgt_rep = pri_master_i.active && pri_perr_old_q && !pri_perr_lvl;
   assign sec_tgt_rep = sec_master_i.active && sec_perr_old_q && !sec_perr_lvl;

   // forwarded parity already reached the initiator, so no system error for it
   assign serr_down = sec_tgt_rep && serr_en && !pw_dis && pri_per && sec_per &&
                      !sec_master_i.fwd;                                 // RQ7 RQ10
   assign serr_up   = pri_tgt_rep && serr_en && pri_per && sec_per &&
                      !pri_master_i.fwd;                                 // RQ9 RQ10

   ////////////////////////////////////////////////////////////////////////////
   // wishbone slave and registers

   logic            req;
   logic            rd_stat;
   logic [STAT_W-1:0] set_v;

   assign req     = wb_cyc_i && wb_stb_i && !ack_q;
   assign rd_stat = req && !wb_we_i && (wb_adr_i == ADR_STAT);

   // next values; a status set always beats the clear of a read in the same cycle
   always_comb begin
      ack_d  = req;
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      rdat_d = rdat_q;
      set_v  = '0;
      set_v[STAT_PRI_DPE]  = pri_det;                       // RQ2 RQ11
      set_v[STAT_SEC_DPE]  = sec_det;                       // RQ4 RQ12
      set_v[STAT_PRI_MDPD] = pri_tgt_rep && pri_per;        // RQ8
      set_v[STAT_SEC_MDPD] = sec_tgt_rep && sec_per;        // RQ6
      set_v[STAT_SIG_SERR] = serr_down || serr_up;          // RQ7 RQ9
      stat_d = (rd_stat ? STAT_RST : stat_q) | set_v;
      if (req && wb_we_i && wb_sel_i[0]) begin
         if (wb_adr_i == ADR_CTRL) begin
            ctrl_d = wb_dat_i[CTRL_W-1:0];
         end
         if (wb_adr_i == ADR_MASK) begin
            mask_d = wb_dat_i[STAT_W-1:0];
         end
      end
      if (req && !wb_we_i) begin
         unique case (wb_adr_i)
            ADR_CTRL: rdat_d = {{(32-CTRL_W){1'b0}}, ctrl_q};
            ADR_STAT: rdat_d = {{(32-STAT_W){1'b0}}, stat_q};
            ADR_MASK: rdat_d = {{(32-STAT_W){1'b0}}, mask_q};
            default:  rdat_d = 32'h0000_0000; // unmapped reads answer zero
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         ctrl_q <= CTRL_RST;
         stat_q <= STAT_RST;
         mask_q <= MASK_RST;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= ack_d;
         ctrl_q <= ctrl_d;
         stat_q <= stat_d;
         mask_q <= mask_d;
         rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign irq_o    = |(stat_q & mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // pin drive, forwarding and completion

   logic [PERR_DLY-1:0] pri_pipe_q;
   logic [PERR_DLY-1:0] pri_pipe_d;
   logic [PERR_DLY-1:0] sec_pipe_q;
   logic [PERR_DLY-1:0] sec_pipe_d;
   logic                serr_q;
   logic                serr_d;
   bpr_fwd_s            sec_fwd_q;
   bpr_fwd_s            sec_fwd_d;
   bpr_fwd_s            pri_fwd_q;
   bpr_fwd_s            pri_fwd_d;
   logic                pri_cmpl_q;
   logic                pri_cmpl_d;
   logic                sec_cmpl_q;
   logic                sec_cmpl_d;

   // a short shift line places the parity pin pulse exactly PERR_DLY cycles after the data phase
   always_comb begin
      pri_pipe_d = {pri_pipe_q[PERR_DLY-2:0], pri_pw_err && pri_per};   // RQ1
      sec_pipe_d = {sec_pipe_q[PERR_DLY-2:0], sec_pw_err && sec_per};   // RQ4
      serr_d     = serr_down || serr_up;                                // RQ7 RQ9
      // bad parity travels with the data; the initiator still sees a normal end
      sec_fwd_d.valid   = posted_in(pri_phase_i, DIR_DOWN);             // RQ3
      sec_fwd_d.bad_par = pri_phase_i.bad_par;                          // RQ3
      pri_fwd_d.valid   = posted_in(sec_phase_i, DIR_UP);               // RQ5
      pri_fwd_d.bad_par = sec_phase_i.bad_par;                          // RQ5
      pri_cmpl_d        = posted_in(pri_phase_i, DIR_DOWN);             // RQ3
      sec_cmpl_d        = posted_in(sec_phase_i, DIR_UP);               // RQ5
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pri_pipe_q     <= '0;
         sec_pipe_q     <= '0;
         serr_q         <= 1'b0;
         sec_fwd_q      <= '0;
         pri_fwd_q      <= '0;
         pri_cmpl_q     <= 1'b0;
         sec_cmpl_q     <= 1'b0;
         pri_perr_old_q <= 1'b1;
         sec_perr_old_q <= 1'b1;
      end else begin
         pri_pipe_q     <= pri_pipe_d;
         sec_pipe_q     <= sec_pipe_d;
         serr_q         <= serr_d;
         sec_fwd_q      <= sec_fwd_d;
         pri_fwd_q      <= pri_fwd_d;
         pri_cmpl_q     <= pri_cmpl_d;
         sec_cmpl_q     <= sec_cmpl_d;
         pri_perr_old_q <= pri_perr_lvl;
         sec_perr_old_q <= sec_perr_lvl;
      end
   end

   // pins are driven low only while enabled; otherwise the wire floats high
   assign upstream_side_parity_err_n_o      = ~pri_pipe_q[PERR_DLY-1];
   assign upstream_side_parity_err_n_oe_o   = pri_pipe_q[PERR_DLY-1];
   assign downstream_side_parity_err_n_o    = ~sec_pipe_q[PERR_DLY-1];
   assign downstream_side_parity_err_n_oe_o = sec_pipe_q[PERR_DLY-1];
   assign upstream_side_system_err_n_o      = ~serr_q;
   assign upstream_side_system_err_n_oe_o   = serr_q;
   assign sec_fwd_o  = sec_fwd_q;
   assign pri_fwd_o  = pri_fwd_q;
   assign pri_cmpl_o = pri_cmpl_q;
   assign sec_cmpl_o = sec_cmpl_q;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_pri_pin_late;
      ##2 upstream_side_parity_err_n_oe_o && !upstream_side_parity_err_n_o;
   endsequence

   sequence s_sec_pin_late;
      ##2 downstream_side_parity_err_n_oe_o && !downstream_side_parity_err_n_o;
   endsequence

   property p_pri_perr_late;
      pri_pw_err && pri_per |-> s_pri_pin_late;
   endproperty
   a_pri_perr_late: assert property (p_pri_perr_late) // RQ1
      else $error("primary parity pin not driven two cycles after bad posted write");

   property p_pri_perr_cause;
      upstream_side_parity_err_n_oe_o |-> $past(pri_pw_err, 2) && $past(pri_per, 2);
   endproperty
   a_pri_perr_cause: assert property (p_pri_perr_cause) // RQ1
      else $error("primary parity pin driven without an enabled cause");

   property p_pri_dpe_set;
      pri_pw_err |=> stat_q[STAT_PRI_DPE];
   endproperty
   a_pri_dpe_set: assert property (p_pri_dpe_set) // RQ2
      else $error("primary detected parity bit not set");

   property p_fwd_down;
      posted_in(pri_phase_i, DIR_DOWN) |=>
         sec_fwd_o.valid && pri_cmpl_o && (sec_fwd_o.bad_par == $past(pri_phase_i.bad_par));
   endproperty
   a_fwd_down: assert property (p_fwd_down) // RQ3
      else $error("downstream posted write not forwarded with its parity");

   property p_sec_perr_late;
      sec_pw_err && sec_per |-> s_sec_pin_late;
   endproperty
   a_sec_perr_late: assert property (p_sec_perr_late) // RQ4
      else $error("secondary parity pin not driven two cycles after bad posted write");

   property p_fwd_up;
      posted_in(sec_phase_i, DIR_UP) |=>
         pri_fwd_o.valid && sec_cmpl_o && (pri_fwd_o.bad_par == $past(sec_phase_i.bad_par));
   endproperty
   a_fwd_up: assert property (p_fwd_up) // RQ5
      else $error("upstream posted write not forwarded with its parity");

   property p_sec_mdpd;
      $rose(stat_q[STAT_SEC_MDPD]) |-> $past(sec_tgt_rep) && $past(sec_per);
   endproperty
   a_sec_mdpd: assert property (p_sec_mdpd) // RQ6
      else $error("secondary master parity bit set without enabled report");

   property upstream_side_system_err_n_down;
      sec_tgt_rep && serr_en && !pw_dis && pri_per && sec_per && !sec_master_i.fwd |=>
         upstream_side_system_err_n_oe_o && stat_q[STAT_SIG_SERR];
   endproperty
   a_serr_down: assert property (upstream_side_system_err_n_down) // RQ7
      else $error("system error missing for downstream target report");

   property p_pri_mdpd;
      pri_tgt_rep && pri_per |=> stat_q[STAT_PRI_MDPD];
   endproperty
   a_pri_mdpd: assert property (p_pri_mdpd) // RQ8
      else $error("primary master parity bit not set");

   property upstream_side_system_err_n_up;
      pri_tgt_rep && serr_en && pri_per && sec_per && !pri_master_i.fwd |=>
         upstream_side_system_err_n_oe_o && stat_q[STAT_SIG_SERR];
   endproperty
   a_serr_up: assert property (upstream_side_system_err_n_up) // RQ9
      else $error("system error missing for upstream target report");

   property p_no_serr_fwd;
      upstream_side_system_err_n_oe_o |->
         $past(sec_tgt_rep && !sec_master_i.fwd) || $past(pri_tgt_rep && !pri_master_i.fwd);
   endproperty
   a_no_serr_fwd: assert property (p_no_serr_fwd) // RQ10
      else $error("system error raised for forwarded parity");

   property p_pri_dpe_only;
      $rose(stat_q[STAT_PRI_DPE]) |-> $past(pri_det);
   endproperty
   a_pri_dpe_only: assert property (p_pri_dpe_only) // RQ11
      else $error("primary detected parity bit set without primary error");

   property p_sec_dpe_only;
      $rose(stat_q[STAT_SEC_DPE]) |-> $past(sec_det);
   endproperty
   a_sec_dpe_only: assert property (p_sec_dpe_only) // RQ12
      else $error("secondary detected parity bit set without secondary error");

endmodule : bpr_parity_report
`default_nettype wire

// file: testbench/bpr_far_side_model.sv
// far-side pci targets that report data parity errors on the shared error pins
`default_nettype none
module bpr_far_side_model #(
   parameter int HOLD = 4
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // report requests from the bench, one-cycle pulses
   input  wire logic pri_rep_i,
   input  wire logic sec_rep_i,
   // bridge drive of both parity pins
   input  wire logic up_n_i,
   input  wire logic up_oe_i,
   input  wire logic dn_n_i,
   input  wire logic dn_oe_i,
   // resolved wire levels, pulled up when nobody drives
   output logic      up_lvl_o,
   output logic      dn_lvl_o
);
   logic [3:0] pri_cnt_q;
   logic [3:0] pri_cnt_d;
   logic [3:0] sec_cnt_q;
   logic [3:0] sec_cnt_d;

   ////////////////////////////////////////////////////////////////////////////
   // a report is held a few cycles so that the bridge pin filter agrees on it
   always_comb begin
      pri_cnt_d = pri_rep_i ? 4'(HOLD) : pri_cnt_q - 4'((pri_cnt_q != 4'h0));
      sec_cnt_d = sec_rep_i ? 4'(HOLD) : sec_cnt_q - 4'((sec_cnt_q != 4'h0));
   end

   always_ff @(posedge clk_i) begin
      pri_cnt_q <= rst_i ? 4'h0 : pri_cnt_d;
      sec_cnt_q <= rst_i ? 4'h0 : sec_cnt_d;
   end

   // open-drain wire: low if either party pulls, else the pull-up wins
   assign up_lvl_o = !(up_oe_i && !up_n_i) && (pri_cnt_q == 4'h0);
   assign dn_lvl_o = !(dn_oe_i && !dn_n_i) && (sec_cnt_q == 4'h0);
endmodule : bpr_far_side_model
`default_nettype wire

// file: testbench/bpr_parity_report_tb.sv
// self-checking bench of the posted write parity report block
`default_nettype none
module bpr_parity_report_tb
   import bpr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {
      logic       sec;
      logic       fwd;
      logic [3:0] ctrl;
      logic [4:0] stat;
      logic       serr;
   } bpr_rep_s;

   logic        clk_i, rst_i, cyc, stb, we, ack, irq, pri_rep, sec_rep;
   logic [3:0]  adr, sel;
   logic [31:0] wdat, rdat, q;
   bpr_phase_s  pri_ph, sec_ph;
   bpr_master_s pri_ms, sec_ms;
   bpr_fwd_s    sec_fwd, pri_fwd;
   logic        pri_cmpl, sec_cmpl, up_lvl, dn_lvl, up_n, up_oe, dn_n, dn_oe, serr_n, serr_oe;
   int          fail_count, tests_run, cyc_cnt, serr_cnt;
   bpr_xact_e   kinds [3] = '{XACT_READ, XACT_POSTED, XACT_DELAYED};
   bpr_rep_s    reps [9] = '{
      '{1'b1, 1'b0, 4'h7, 5'h18, 1'b1}, '{1'b1, 1'b0, 4'hf, 5'h08, 1'b0},
      '{1'b1, 1'b1, 4'h7, 5'h08, 1'b0}, '{1'b1, 1'b0, 4'h5, 5'h00, 1'b0},
      '{1'b1, 1'b0, 4'h3, 5'h08, 1'b0}, '{1'b0, 1'b0, 4'h7, 5'h14, 1'b1},
      '{1'b0, 1'b0, 4'hf, 5'h14, 1'b1}, '{1'b0, 1'b1, 4'h7, 5'h04, 1'b0},
      '{1'b0, 1'b0, 4'h6, 5'h00, 1'b0}};

   bpr_parity_report u_bpr_parity_report (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .pri_phase_i(pri_ph), .sec_phase_i(sec_ph), .pri_master_i(pri_ms), .sec_master_i(sec_ms),
      .sec_fwd_o(sec_fwd), .pri_fwd_o(pri_fwd), .pri_cmpl_o(pri_cmpl), .sec_cmpl_o(sec_cmpl),
      .upstream_side_parity_err_n_i(up_lvl), .upstream_side_parity_err_n_o(up_n),
      .upstream_side_parity_err_n_oe_o(up_oe), .downstream_side_parity_err_n_i(dn_lvl),
      .downstream_side_parity_err_n_o(dn_n), .downstream_side_parity_err_n_oe_o(dn_oe),
      .upstream_side_system_err_n_o(serr_n), .upstream_side_system_err_n_oe_o(serr_oe),
      .irq_o(irq));

   bpr_far_side_model u_bpr_far_side_model (
      .clk_i(clk_i), .rst_i(rst_i), .pri_rep_i(pri_rep), .sec_rep_i(sec_rep),
      .up_n_i(up_n), .up_oe_i(up_oe), .dn_n_i(dn_n), .dn_oe_i(dn_oe),
      .up_lvl_o(up_lvl), .dn_lvl_o(dn_lvl));

   ////////////////////////////////////////////////////////////////////////////
   // clock, hang guard and system error pulse counter
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = !clk_i;
   end

   always @(posedge clk_i) begin
      cyc_cnt++;
      if (serr_oe === 1'b1 && serr_n === 1'b0) serr_cnt++;
      if (cyc_cnt == 20000) begin
         fail_count++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // one classic cycle; read data is taken at the edge that sees ack
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      {cyc, stb} <= 2'b00;
      chk("wb ack", 32'h0000_0001, {31'h0, ack});
   endtask : wb

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string name);
      wb(1'b0, a, 32'h0000_0000);
      chk(name, exp, q);
   endtask : rd_chk

   // one data phase on one bus; returns settled in the cycle after it is taken
   task automatic phase(input logic s, input bpr_phase_s ph);
      @(posedge clk_i);
      if (s) sec_ph <= ph;
      else pri_ph <= ph;
      @(posedge clk_i);
      pri_ph <= '0;
      sec_ph <= '0;
      #1;
   endtask : phase

   task automatic end_sim;
      if (fail_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic s, w;
      bpr_dir_e d;
      {cyc, stb, we, adr, wdat, pri_rep, sec_rep} = '0;
      {pri_ph, sec_ph, pri_ms, sec_ms} = '0;
      sel = 4'hf;
      rst_i = 1'b1;
      {fail_count, tests_run, cyc_cnt, serr_cnt} = '0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values, an unmapped place, unused upper bits
      rd_chk(ADR_CTRL, 32'(CTRL_RST), "ctrl reset");
      rd_chk(ADR_STAT, 32'(STAT_RST), "status reset");
      rd_chk(ADR_MASK, 32'(MASK_RST), "mask reset");
      rd_chk(4'hc, 32'h0000_0000, "unmapped");
      wb(1'b1, ADR_CTRL, 32'hffff_fff0);
      rd_chk(ADR_CTRL, 32'h0000_0000, "ctrl upper bits");
      // detected bits for every kind, direction and bus, responses off
      for (int k = 0; k < 12; k++) begin
         s = k[0];
         d = bpr_dir_e'(k[1]);
         w = (kinds[k / 4] != XACT_READ);
         phase(s, '{1'b1, 1'b1, kinds[k / 4], d});
         rd_chk(ADR_STAT, {30'h0, s && (w == d), !s && (w != d)}, "detected");
      end
      phase(1'b0, '{1'b1, 1'b0, XACT_POSTED, DIR_DOWN});
      chk("fwd good", 32'h0000_0002, {30'h0, sec_fwd});
      rd_chk(ADR_STAT, 32'h0000_0000, "good parity");
      // posted writes with bad parity, response of one bus at a time, irq on primary only
      wb(1'b1, ADR_MASK, 32'h0000_0001);
      for (int i = 0; i < 4; i++) begin
         s = i[1];
         wb(1'b1, ADR_CTRL, 32'(1 << i[0]));
         phase(s, '{1'b1, 1'b1, XACT_POSTED, bpr_dir_e'(s)});
         chk("fwd", {30'h0, 2'b11}, s ? {30'h0, pri_fwd} : {30'h0, sec_fwd});
         chk("cmpl", 32'h0000_0001, {31'h0, s ? sec_cmpl : pri_cmpl});
         @(posedge clk_i);
         #1;
         chk("perr pin", {30'h0, i[0] == s, i[0] != s}, {30'h0, s ? {dn_oe, dn_n} : {up_oe, up_n}});
         chk("irq set", {31'h0, !s}, {31'h0, irq});
         rd_chk(ADR_STAT, s ? 32'h0000_0002 : 32'h0000_0001, "posted status");
         chk("irq clear", 32'h0000_0000, {31'h0, irq});
      end
      // target reports on the far bus during bridge master writes
      for (int i = 0; i < 9; i++) begin
         wb(1'b1, ADR_CTRL, {28'h0, reps[i].ctrl});
         serr_cnt = 0;
         @(posedge clk_i);
         if (reps[i].sec) {sec_ms, sec_rep} <= {1'b1, reps[i].fwd, 1'b1};
         else {pri_ms, pri_rep} <= {1'b1, reps[i].fwd, 1'b1};
         @(posedge clk_i);
         {sec_rep, pri_rep} <= 2'b00;
         repeat (12) @(posedge clk_i);
         {sec_ms, pri_ms} <= '0;
         rd_chk(ADR_STAT, {27'h0, reps[i].stat}, "report status");
         chk("serr pulses", {31'h0, reps[i].serr}, serr_cnt);
      end
      end_sim();
   end
endmodule : bpr_parity_report_tb
`default_nettype wire
